// >>> include/mai_pkg.sv
// Package for the memory auto-initialization controller: register map, fields, resets
package mai_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAI_GLOBAL_CTRL_OFS = 8'h00; // memory_init_global_ctrl
  localparam logic [7:0] MAI_SELECT_OFS      = 8'h04; // memory_init_select
  localparam logic [7:0] MAI_STATUS_OFS      = 8'h08; // busy / done / active select

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  MAI_KEY_ENABLE      = 4'ha;     // Global ctrl key that starts a run
  localparam logic [3:0]  MAI_KEY_RESET       = 4'h5;     // Global ctrl value after reset
  localparam int          MAI_STAT_DONE_BIT   = 8;        // Status: sequence complete (sticky)
  localparam int          MAI_STAT_BUSY_BIT   = 9;        // Status: sequence running
  localparam logic [31:0] MAI_SELECT_RESET    = 32'h0000_0000;
  localparam int          MAI_NUM_MEM         = 15;       // Select bits 0..14
  localparam int          MAI_RESERVED_BIT    = 9;        // No memory behind this bit
  localparam logic [14:0] MAI_VALID_MASK      = 15'h7dff; // Every bit except the reserved one

  // Memory index per select bit
  localparam int MAI_SYS_RAM      = 0;
  localparam int MAI_DMA_RAM      = 1;
  localparam int MAI_VECTOR_RAM   = 2;
  localparam int MAI_TIMER_RAM    = 3;
  localparam int MAI_TIMER_TU_RAM = 4;
  localparam int MAI_CAN_ONE      = 5;
  localparam int MAI_CAN_TWO      = 6;
  localparam int MAI_SPI_ONE      = 7;
  localparam int MAI_ADC_ONE      = 8;
  localparam int MAI_CAN_THREE    = 10;
  localparam int MAI_SPI_THREE    = 11;
  localparam int MAI_SPI_FIVE     = 12;
  localparam int MAI_NET_TU_RAM   = 13;
  localparam int MAI_ADC_TWO      = 14;

  // Error-detection scheme codes per memory
  localparam logic [1:0] MAI_SCHEME_NONE   = 2'h0;
  localparam logic [1:0] MAI_SCHEME_EVEN   = 2'h1;
  localparam logic [1:0] MAI_SCHEME_ODD    = 2'h2;
  localparam logic [1:0] MAI_SCHEME_ECC    = 2'h3;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    MAI_IDLE  = 3'b001,
    MAI_WRITE = 3'b010,
    MAI_NEXT  = 3'b100
  } mai_state_e;

endpackage

// >>> rtl/mai_ctrl.sv
// Memory auto-initialization controller with APB register slave and memory write port
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Write each selected array to a state matching its parity or ECC scheme.
// - Start the sequence only when software writes the enable key to global control.
// - Initialize only memories whose select bit is set; leave others untouched.
// - Bit 0 system RAM, bit 1 DMA packet RAM, bit 2 vector table RAM.
// - Bit 3 timer program RAM, bit 4 timer transfer RAM, bit 13 network transfer RAM.
// - Bits 5, 6, 10 are the first, second, third CAN message RAMs.
// - Bits 7, 11, 12 are the first, third, fifth buffered SPI RAMs.
// - Bit 8 first ADC buffer RAM, bit 14 second ADC buffer RAM.
// - Bit 9 is reserved and starts no initialization.
// - With ECC enabled, the memory's ECC storage is written in the same pass.
// - With parity enabled, the memory's parity storage is written in the same pass.
module mai_ctrl
  import mai_pkg::*;
#(
  parameter int AW = 16 // Word address width of the memory write port
) (
  input  wire logic                          clk,          // 10 MHz system clock
  input  wire logic                          rst,          // Synchronous reset, active high
  input  wire logic                          psel,         // APB select
  input  wire logic                          penable,      // APB access phase
  input  wire logic                          pwrite,       // APB direction
  input  wire logic [7:0]                    paddr,        // APB byte address
  input  wire logic [31:0]                   pwdata,       // APB write data
  output logic                               pready,       // APB ready
  output logic [31:0]                        prdata,       // APB read data
  output logic                               pslverr,      // APB error on unmapped address
  input  wire logic [MAI_NUM_MEM-1:0][AW-1:0] mem_last,    // Last word address per memory
  input  wire logic [MAI_NUM_MEM-1:0]        ecc_en,       // ECC enabled per memory
  input  wire logic [MAI_NUM_MEM-1:0]        par_en,       // Parity enabled per memory
  input  wire logic [MAI_NUM_MEM-1:0]        par_odd,      // Parity is odd per memory
  output logic [MAI_NUM_MEM-1:0]             mem_we,       // Write strobe per memory
  output logic [AW-1:0]                      mem_addr,     // Word address being written
  output logic                               mem_chk_we,   // ECC or parity array written too
  output logic [1:0]                         mem_scheme,   // Check scheme of this write
  output logic                               init_busy,    // Sequence running
  output logic                               init_done     // Sequence complete, sticky
);
  import mai_pkg::*;

  // ----------------------------------------------------------------
  // Operating notes
  // ----------------------------------------------------------------
  // One memory at a time, lowest select bit first, one word per clock.
  // Each memory takes its last address plus two clocks, one extra to pick it.
  // Data words are all zero; the check scheme travels on mem_scheme.
  // Zero data keeps even parity and ECC check bits trivially consistent.
  // Odd parity still needs the check array written, hence mem_chk_we.
  // Select is frozen while running, so software cannot shrink a live pass.
  // A second enable key during a run is dropped rather than queued.
  // Done stays set until the next run starts; reset clears it too.
  // Memories stay unusable while busy; software should poll status first.
  // System RAM must finish before its ECC checking is switched on.
  // Bit 9 is stored and read back but never starts a write.
  // Memory sizes come in on mem_last so one block serves any array size.
  // Reads cost one wait state; writes complete in their first access cycle.
  // Unmapped offsets answer with pslverr and read as zero.

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [3:0]             global_key;
  logic [31:0]            select;
  logic [MAI_NUM_MEM-1:0] pending;
  logic [3:0]             cur;
  logic [AW-1:0]          addr;
  logic                   done;
  mai_state_e             state;

  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic start;
  logic rd_wait;
  logic last_word;
  mai_state_e next_state;

  // Lowest pending memory index; the priority order is fixed low to high
  function automatic logic [3:0] first_set(input logic [MAI_NUM_MEM-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = MAI_NUM_MEM - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Scheme code of a memory from its enables
  function automatic logic [1:0] scheme_of(input logic e, input logic p, input logic o);
    logic [1:0] s;
    s = MAI_SCHEME_NONE;
    if (e) begin
      s = MAI_SCHEME_ECC;
    end else if (p) begin
      s = o ? MAI_SCHEME_ODD : MAI_SCHEME_EVEN;
    end
    return s;
  endfunction

  // Status word: busy, sticky done and the memory index being worked on
  function automatic logic [31:0] status_word(input logic b, input logic d, input logic [3:0] c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[MAI_STAT_BUSY_BIT] = b;
    w[MAI_STAT_DONE_BIT] = d;
    w[3:0] = c;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Memory strobe decode
  // ----------------------------------------------------------------
  // One-hot write strobe for a memory index; the reserved index maps to nothing
  function automatic logic [MAI_NUM_MEM-1:0] strobe_of(input logic [3:0] idx);
    logic [MAI_NUM_MEM-1:0] s;
    s = '0;
    case (idx)
      4'(MAI_SYS_RAM): begin
        s[MAI_SYS_RAM] = 1'b1;
      end
      4'(MAI_DMA_RAM): begin
        s[MAI_DMA_RAM] = 1'b1;
      end
      4'(MAI_VECTOR_RAM): begin
        s[MAI_VECTOR_RAM] = 1'b1;
      end
      4'(MAI_TIMER_RAM): begin
        s[MAI_TIMER_RAM] = 1'b1;
      end
      4'(MAI_TIMER_TU_RAM): begin
        s[MAI_TIMER_TU_RAM] = 1'b1;
      end
      4'(MAI_NET_TU_RAM): begin
        s[MAI_NET_TU_RAM] = 1'b1;
      end
      4'(MAI_CAN_ONE): begin
        s[MAI_CAN_ONE] = 1'b1;
      end
      4'(MAI_CAN_TWO): begin
        s[MAI_CAN_TWO] = 1'b1;
      end
      4'(MAI_CAN_THREE): begin
        s[MAI_CAN_THREE] = 1'b1;
      end
      4'(MAI_SPI_ONE): begin
        s[MAI_SPI_ONE] = 1'b1;
      end
      4'(MAI_SPI_THREE): begin
        s[MAI_SPI_THREE] = 1'b1;
      end
      4'(MAI_SPI_FIVE): begin
        s[MAI_SPI_FIVE] = 1'b1;
      end
      4'(MAI_ADC_ONE): begin
        s[MAI_ADC_ONE] = 1'b1;
      end
      4'(MAI_ADC_TWO): begin
        s[MAI_ADC_TWO] = 1'b1;
      end
      default: begin
        s = '0;
      end
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // APB decode: writes finish at once, reads after one wait state
  // ----------------------------------------------------------------
  assign mapped = (paddr == MAI_GLOBAL_CTRL_OFS) || (paddr == MAI_SELECT_OFS) ||
                  (paddr == MAI_STATUS_OFS);
  assign wr_acc = psel && penable && pwrite && mapped;
  // Reads take one wait state so prdata is a flop yet valid when pready is sampled
  assign rd_acc = psel && penable && !pwrite && !rd_wait;
  assign pready = !(psel && penable && !pwrite) || rd_wait;
  assign pslverr = psel && penable && !mapped;

  // A run starts on the key write only while idle; a second key mid-run is ignored
  assign start = wr_acc && (paddr == MAI_GLOBAL_CTRL_OFS) &&
                 (pwdata[3:0] == MAI_KEY_ENABLE) && (state == MAI_IDLE);

  // Global control key register
  always_ff @(posedge clk) begin
    if (rst) begin
      global_key <= MAI_KEY_RESET;
    end else if (wr_acc && paddr == MAI_GLOBAL_CTRL_OFS) begin
      global_key <= pwdata[3:0];
    end
  end

  // Select register; locked while running so the pass sees a stable set
  always_ff @(posedge clk) begin
    if (rst) begin
      select <= MAI_SELECT_RESET;
    end else if (wr_acc && paddr == MAI_SELECT_OFS && state == MAI_IDLE) begin
      select <= {17'h0, pwdata[MAI_NUM_MEM-1:0]};
    end
  end

  // Read wait state: high in the second access cycle of a read only
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= rd_acc;
    end
  end

  // Read data is registered
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc) begin
      case (paddr)
        MAI_GLOBAL_CTRL_OFS: prdata <= {28'h0, global_key};
        MAI_SELECT_OFS:      prdata <= select;
        MAI_STATUS_OFS:      prdata <= status_word(state != MAI_IDLE, done, cur);
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: walks pending memories one after another, word by word
  // ----------------------------------------------------------------
  assign last_word = (addr == mem_last[cur]);

  // Next state: idle, then pick a memory, then write its words
  always_comb begin
    next_state = state;
    case (state)
      MAI_IDLE: begin
        if (start) begin
          next_state = MAI_NEXT;
        end
      end
      MAI_NEXT: begin
        if (pending == '0) begin
          next_state = MAI_IDLE;
        end else begin
          next_state = MAI_WRITE;
        end
      end
      MAI_WRITE: begin
        if (last_word) begin
          next_state = MAI_NEXT;
        end
      end
      default: begin
        next_state = MAI_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= MAI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pending set: loaded on start, a bit dropped as its memory completes
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= '0;
    end else if (state == MAI_IDLE && start) begin
      // Reserved bit masked out so it never triggers a write
      pending <= select[MAI_NUM_MEM-1:0] & MAI_VALID_MASK;
    end else if (state == MAI_WRITE && last_word) begin
      pending[cur] <= 1'b0;
    end
  end

  // Memory being written: lowest pending index first
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= 4'h0;
    end else if (state == MAI_NEXT && pending != '0) begin
      cur <= first_set(pending);
    end
  end

  // Word address inside the current memory; restarts at zero for each memory
  always_ff @(posedge clk) begin
    if (rst) begin
      addr <= '0;
    end else if (state == MAI_NEXT) begin
      addr <= '0;
    end else if (state == MAI_WRITE && !last_word) begin
      addr <= addr + 1'b1;
    end
  end

  // Done is sticky; cleared by the next start, set wins when the run ends
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (state == MAI_NEXT && pending == '0) begin
      done <= 1'b1;
    end else if (start) begin
      done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Memory write port, registered; data is all zero, check bits follow scheme
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_we     <= '0;
      mem_addr   <= '0;
      mem_chk_we <= 1'b0;
      mem_scheme <= MAI_SCHEME_NONE;
    end else begin
      mem_we   <= '0;
      mem_addr <= addr;
      if (state == MAI_WRITE) begin
        mem_we <= strobe_of(cur);
        // Check storage written alongside the data when its scheme is enabled
        mem_chk_we <= ecc_en[cur] || par_en[cur];
        mem_scheme <= scheme_of(ecc_en[cur], par_en[cur], par_odd[cur]);
      end else begin
        mem_chk_we <= 1'b0;
        mem_scheme <= MAI_SCHEME_NONE;
      end
    end
  end

  assign init_busy = (state != MAI_IDLE);
  assign init_done = done;

endmodule
`default_nettype wire

// >>> testbench/mai_ctrl_props.sv
// Port checker for the memory auto-init controller
`timescale 1ns/100ps
`default_nettype none
module mai_ctrl_props
  import mai_pkg::*;
#(parameter int AW = 16) (
  input wire logic                   clk,        // Clock
  input wire logic                   rst,        // Reset
  input wire logic                   psel,       // Select
  input wire logic                   penable,    // Access
  input wire logic                   pwrite,     // Direction
  input wire logic [7:0]             paddr,      // Address
  input wire logic [31:0]            pwdata,     // Write data
  input wire logic [MAI_NUM_MEM-1:0] ecc_en,     // ECC on
  input wire logic [MAI_NUM_MEM-1:0] par_en,     // Parity on
  input wire logic [MAI_NUM_MEM-1:0] par_odd,    // Odd parity
  input wire logic [MAI_NUM_MEM-1:0] mem_we,     // Word strobes
  input wire logic [1:0]             mem_scheme, // Check scheme
  input wire logic                   mem_chk_we, // Check write
  input wire logic                   init_busy,  // Running
  input wire logic                   init_done   // Finished
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic kick;
  // Key write seen at an access edge
  assign kick = psel && penable && pwrite && paddr == MAI_GLOBAL_CTRL_OFS
    && pwdata[3:0] == MAI_KEY_ENABLE;
  a_start_busy: assert property (kick && !init_busy |=> init_busy)
    else $error("key did not start a run");
  a_no_start: assert property (!init_busy && !kick |=> !init_busy)
    else $error("run began without key");
  a_reserved_quiet: assert property (!mem_we[MAI_RESERVED_BIT])
    else $error("reserved memory written");
  a_one_memory: assert property ($onehot0(mem_we))
    else $error("two memories written at once");
  a_write_in_run: assert property (|mem_we |-> $past(init_busy))
    else $error("write outside a run");
  a_ecc_check: assert property (|(mem_we & ecc_en) |->
    mem_chk_we && mem_scheme == MAI_SCHEME_ECC) else $error("ecc store skipped");
  a_par_check: assert property (|(mem_we & par_en & ~ecc_en) |-> mem_chk_we && mem_scheme ==
    (|(mem_we & par_odd) ? MAI_SCHEME_ODD : MAI_SCHEME_EVEN)) else $error("parity wrong");
  a_done_after: assert property ($fell(init_busy) |-> ##[0:1] init_done)
    else $error("no done after run");
endmodule
`default_nettype wire

// >>> testbench/mai_mem_model.sv
// Behavioural on-chip RAMs that count the words written into each
`timescale 1ns/100ps
`default_nettype none
module mai_mem_model (
  input wire logic         clk,      // Clock
  input wire logic         clr,      // Clear counts
  input wire logic [14:0]  mem_we,   // Word strobes
  input wire logic [15:0]  mem_addr, // Word address
  output logic [14:0][15:0] mem_last, // Last word per RAM
  output logic [14:0]      ecc_en,   // ECC on
  output logic [14:0]      par_en,   // Parity on
  output logic [14:0]      par_odd,  // Odd parity
  output logic [15:0]      cnt [15]  // Words written
);
  // Tiny arrays keep runs short; sizes differ so a mixup shows
  always_comb begin
    for (int i = 0; i < 15; i++) mem_last[i] = 16'(i % 4 + 1);
  end
  // System RAM has ECC, vector RAM no checks, the rest mixed parity
  assign ecc_en = 15'h0001;
  assign par_en = 15'h7dfa;
  assign par_odd = 15'h5550;
  // Out-of-range writes are not counted so they show as a miss
  always @(posedge clk) begin
    for (int i = 0; i < 15; i++) begin
      if (clr) cnt[i] <= 16'h0;
      else if (mem_we[i] && mem_addr <= mem_last[i]) cnt[i] <= cnt[i] + 16'h1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_memory_auto_init_control.sv
// Register-level tests of the memory auto-init controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module test_memory_auto_init_control;
  import mai_pkg::*;
  logic clk, rst, psel, penable, pwrite, clr, pready, pslverr, mem_chk_we, init_busy, init_done, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [14:0] mem_we, ecc_en, par_en, par_odd;
  logic [15:0] mem_addr;
  logic [1:0] mem_scheme;
  logic [14:0][15:0] mem_last;
  logic [15:0] cnt [15];
  int num_errors = 0;
  int total_checks = 0;
  mai_ctrl dut_u (
    .clk        (clk),
    .rst        (rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pready     (pready),
    .prdata     (prdata),
    .pslverr    (pslverr),
    .mem_last   (mem_last),
    .ecc_en     (ecc_en),
    .par_en     (par_en),
    .par_odd    (par_odd),
    .mem_we     (mem_we),
    .mem_addr   (mem_addr),
    .mem_chk_we (mem_chk_we),
    .mem_scheme (mem_scheme),
    .init_busy  (init_busy),
    .init_done  (init_done)
  );
  mai_mem_model mem_u (
    .clk      (clk),
    .clr      (clr),
    .mem_we   (mem_we),
    .mem_addr (mem_addr),
    .mem_last (mem_last),
    .ecc_en   (ecc_en),
    .par_en   (par_en),
    .par_odd  (par_odd),
    .cnt      (cnt)
  );
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // One transfer; response and read data are taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    // Sample just before each edge, where the slave outputs are settled
    do begin
      @(negedge clk);
      rdy = pready;
      err = pslverr;
      q = prdata;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) num_errors++;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  // Select, start, optionally poke while busy, then wait for the end
  task automatic run(input logic [31:0] sel, input logic poke);
    int n;
    clr <= 1;
    apb(1, MAI_SELECT_OFS, sel);
    clr <= 0;
    apb(1, MAI_GLOBAL_CTRL_OFS, 32'(MAI_KEY_ENABLE));
    if (poke) apb(1, MAI_SELECT_OFS, 32'h0);
    n = 0;
    do begin @(negedge clk); n++; end while (init_busy !== 1'b0 && n < 500);
    `CHK("done", 1'b1, init_done)
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2000000 num_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; clr = 0;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, MAI_GLOBAL_CTRL_OFS, 0); `CHK("ctrl", {28'h0, MAI_KEY_RESET}, q)
    apb(0, MAI_SELECT_OFS, 0); `CHK("select", MAI_SELECT_RESET, q)
    apb(0, 8'h0c, 0); `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, q)
    $display("reset test done");
    // Bit 15 stands for an empty selection
    for (int b = 0; b < 16; b++) begin
      run((b == 15) ? 32'h0 : 32'h1 << b, 0);
      for (int i = 0; i < 15; i++)
        `CHK("words", (i == b && i != 9) ? 16'(i % 4 + 2) : 16'h0, cnt[i])
    end
    $display("single select test done");
    // Everything at once; the select write while busy must be dropped
    run(32'h7fff, 1);
    apb(0, MAI_SELECT_OFS, 0); `CHK("held select", 32'h7fff, q)
    for (int i = 0; i < 15; i++)
      `CHK("all words", (i != 9) ? 16'(i % 4 + 2) : 16'h0, cnt[i])
    apb(0, MAI_STATUS_OFS, 0); `CHK("status", 2'b01, q[9:8])
    $display("full run test done");
    report_and_stop();
  end
endmodule
bind mai_ctrl mai_ctrl_props #(.AW(AW)) u_props (.*);
`default_nettype wire
